// File: hw/mre_pkg.sv
// shared types and constants of the memory-reference execute unit
// assumes a 16-bit word machine with byte addresses holding the word
// address in the upper fifteen bits
`default_nettype none

package mre_pkg;

  // ==========================================================
  // widths and constants
  localparam int WORD_W        = 16;
  localparam int BYTE_W        = 8;
  localparam int BYTE_SEL_BIT  = 0;

  typedef logic [WORD_W-1:0] mre_word_t;
  typedef logic [BYTE_W-1:0] mre_byte_t;
  typedef logic [1:0]        mre_skip_t;

  localparam mre_word_t WORD_ZERO    = 16'h0000;
  localparam mre_word_t WORD_ONE     = 16'h0001;
  localparam mre_word_t WORD_MAX_POS = 16'h7FFF;
  localparam mre_byte_t BYTE_ZERO    = 8'h00;
  localparam logic      SEL_HIGH     = 1'b0;
  localparam mre_skip_t SKIP_NONE    = 2'h0;
  localparam mre_skip_t SKIP_ONE     = 2'h1;
  localparam mre_skip_t SKIP_TWO     = 2'h2;

  // ==========================================================
  // operations
  typedef enum logic [3:0] {
    op_conj,
    op_incl_or,
    op_excl_or,
    op_load_acc,
    op_load_idx,
    op_store_acc,
    op_store_idx,
    op_exchange,
    op_compare,
    op_increment_and_skip,
    op_unconditional_jump,
    op_jump_and_store_return,
    op_scan
  } mre_op_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    mre_op_t   op;
    logic      byte_mode;
    logic      intr_instr;
    mre_word_t ea;
    mre_word_t a;
    mre_word_t x;
    mre_word_t ret_addr;
    mre_word_t inline_addr;
  } mre_cmd_t;

  typedef struct packed {
    logic      req;
    logic      we;
    mre_word_t addr;
    mre_word_t wdata;
  } mre_mem_req_t;

  typedef struct packed {
    logic      done;
    logic      a_we;
    mre_word_t a_val;
    logic      x_we;
    mre_word_t x_val;
    logic      p_we;
    mre_word_t p_val;
    mre_skip_t skip;
    logic      overflow_flag_set;
    logic      echo;
    logic      int_disable;
    logic      int_hold;
    logic      suspend;
  } mre_result_t;

  // ==========================================================
  // helpers
  function automatic mre_byte_t lo(input mre_word_t w);
    return w[BYTE_W-1:0];
  endfunction

  function automatic mre_byte_t hi(input mre_word_t w);
    return w[WORD_W-1:BYTE_W];
  endfunction

  function automatic mre_word_t word_addr(input mre_word_t a,
                                         input logic      is_byte);
    return is_byte ? {1'b0, a[WORD_W-1:1]} : a;
  endfunction

  // increment, jumps ignore byte mode
  function automatic logic uses_byte(input mre_op_t op,
                                     input logic    byte_mode);
    return byte_mode && (op != op_increment_and_skip) &&
           (op != op_unconditional_jump) &&
           (op != op_jump_and_store_return);
  endfunction

endpackage

`default_nettype wire

// File: hw/mre_byte_lane.sv
// byte extraction and byte merge for one memory word
// assumes the byte select bit comes from a byte address
`default_nettype none

module mre_byte_lane
  import mre_pkg::*;
(
  input  wire logic      sel,
  input  wire mre_word_t word,
  input  wire mre_byte_t wr_byte,
  output mre_word_t      rd_ext,
  output mre_word_t      merged
);

  // ==========================================================
  // lane select
  always_comb begin
    if (sel == SEL_HIGH) begin
      rd_ext = {BYTE_ZERO, hi(word)};
      merged = {wr_byte, lo(word)};
    end else begin
      rd_ext = {BYTE_ZERO, lo(word)};
      merged = {hi(word), wr_byte};
    end
  end

endmodule

`default_nettype wire

// File: hw/mre_compare.sv
// three-way signed compare of the accumulator with an operand
// assumes byte operands arrive already zero-extended
`default_nettype none

module mre_compare
  import mre_pkg::*;
(
  input  wire mre_word_t a,
  input  wire mre_word_t m,
  output mre_skip_t      skip,
  output logic           eq
);

  // ==========================================================
  // skip outcome
  always_comb begin
    eq = (a == m);
    if (eq) begin
      skip = SKIP_TWO;
    end else if ($signed(a) > $signed(m)) begin
      skip = SKIP_ONE;
    end else begin
      skip = SKIP_NONE;
    end
  end

endmodule

`default_nettype wire

// File: hw/mre_execute_unit.sv
// execute unit for single-word memory-reference instructions
// assumes main memory holds requests until mem_ack, with read data
// valid in the ack cycle; effective addresses come in with cmd
`default_nettype none

module mre_execute_unit
  import mre_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst,
  input  wire logic      start,
  input  wire mre_cmd_t  cmd,
  input  wire logic      irq_pending,
  input  wire logic      variant_hold_en,
  input  wire logic      mem_ack,
  input  wire mre_word_t mem_rdata,
  output mre_mem_req_t   mem,
  output mre_result_t    res,
  output logic           busy
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    st_idle,
    st_ptr,
    st_read,
    st_scan,
    st_write
  } mre_phase_t;

  typedef struct packed {
    mre_phase_t   phase;
    mre_op_t      op;
    logic         byte_mode;
    logic         intr;
    logic         busy;
    mre_word_t    a;
    mre_word_t    x;
    mre_word_t    ret;
    mre_word_t    ea;
    mre_word_t    ptr;
    mre_word_t    opnd;
    mre_mem_req_t mem;
    mre_result_t  pend;
    mre_result_t  res;
  } mre_core_t;

  mre_core_t s_reg;
  mre_core_t s_next;

  mre_word_t scan_sum;
  mre_word_t lane_rd;
  mre_word_t lane_merged;
  mre_byte_t lane_wr;
  logic      lane_sel;
  mre_word_t opnd;
  mre_skip_t cmp_skip;
  logic      cmp_eq;

  // ==========================================================
  // operand paths
  assign scan_sum = s_reg.ptr + s_reg.x;
  assign lane_sel = (s_reg.phase == st_scan) ? scan_sum[BYTE_SEL_BIT]
                                             : s_reg.ea[BYTE_SEL_BIT];
  assign lane_wr  = (s_reg.op == op_store_idx) ? lo(s_reg.x)
                                               : lo(s_reg.a);
  assign opnd     = s_reg.byte_mode ? lane_rd : mem_rdata;

  mre_byte_lane u_lane (
    .sel     (lane_sel),
    .word    (mem_rdata),
    .wr_byte (lane_wr),
    .rd_ext  (lane_rd),
    .merged  (lane_merged)
  );

  mre_compare u_cmp (
    .a    (s_reg.a),
    .m    (opnd),
    .skip (cmp_skip),
    .eq   (cmp_eq)
  );

  // ==========================================================
  // next state
  always_comb begin
    mre_result_t r;
    logic        fin;
    logic        rd_go;
    logic        wr_go;
    logic        eb;
    mre_word_t   rd_addr;
    mre_word_t   wr_addr;
    mre_word_t   wr_data;
    mre_word_t   xdec;
    mre_word_t   sum;
    mre_word_t   psum;
    r       = '0;
    fin     = 1'b0;
    rd_go   = 1'b0;
    wr_go   = 1'b0;
    eb      = uses_byte(cmd.op, cmd.byte_mode);
    rd_addr = WORD_ZERO;
    wr_addr = s_reg.mem.addr;
    wr_data = WORD_ZERO;
    xdec    = s_reg.x - WORD_ONE;
    sum     = mem_rdata + WORD_ONE;
    psum    = mem_rdata + s_reg.x;
    s_next      = s_reg;
    s_next.res  = '0;
    unique case (s_reg.phase)
      st_idle: begin
        if (start) begin
          s_next.op        = cmd.op;
          s_next.byte_mode = eb;
          s_next.intr      = cmd.intr_instr;
          s_next.a         = cmd.a;
          s_next.x         = cmd.x;
          s_next.ea        = cmd.ea;
          s_next.busy      = 1'b1;
          s_next.ret       = cmd.intr_instr ? cmd.inline_addr
                                            : cmd.ret_addr;
          wr_addr          = cmd.ea;
          unique case (cmd.op)
            op_scan: begin
              rd_go        = 1'b1;
              rd_addr      = cmd.ea;
              s_next.phase = st_ptr;
            end
            op_unconditional_jump: begin
              r.p_we  = 1'b1;
              r.p_val = cmd.ea;
              fin     = 1'b1;
            end
            op_jump_and_store_return: begin
              wr_go         = 1'b1;
              wr_data       = s_next.ret;
              r.p_we        = 1'b1;
              r.p_val       = cmd.ea + WORD_ONE;
              r.int_disable = cmd.intr_instr;
              r.int_hold    = variant_hold_en;
            end
            op_store_acc,
            op_store_idx: begin
              if (eb) begin
                rd_go        = 1'b1;
                rd_addr      = word_addr(cmd.ea, eb);
                s_next.phase = st_read;
              end else begin
                wr_go   = 1'b1;
                wr_data = (cmd.op == op_store_idx) ? cmd.x : cmd.a;
              end
            end
            default: begin
              rd_go        = 1'b1;
              rd_addr      = word_addr(cmd.ea, eb);
              s_next.phase = st_read;
            end
          endcase
        end
      end
      st_ptr: begin
        if (mem_ack) begin
          s_next.ptr = mem_rdata;
          if (s_reg.x == WORD_ZERO) begin
            r.skip = SKIP_ONE;
            fin    = 1'b1;
          end else begin
            rd_go        = 1'b1;
            rd_addr      = word_addr(psum, s_reg.byte_mode);
            s_next.phase = st_scan;
          end
        end
      end
      st_scan: begin
        if (mem_ack) begin
          r.x_we  = 1'b1;
          r.x_val = xdec;
          s_next.opnd = opnd;
          if (cmp_eq) begin
            fin = 1'b1;
          end else if (xdec == WORD_ZERO) begin
            r.skip = SKIP_ONE;
            fin    = 1'b1;
          end else if (irq_pending) begin
            r.suspend = 1'b1;
            fin       = 1'b1;
          end else begin
            s_next.x        = xdec;
            s_next.mem.addr = word_addr(s_reg.ptr + xdec,
                                        s_reg.byte_mode);
          end
        end
      end
      st_read: begin
        if (mem_ack) begin
          s_next.opnd = opnd;
          fin         = 1'b1;
          unique case (s_reg.op)
            op_conj: begin
              r.a_we  = 1'b1;
              r.a_val = s_reg.byte_mode ?
                        {BYTE_ZERO, lo(s_reg.a) & lo(opnd)} :
                        (s_reg.a & opnd);
            end
            op_incl_or: begin
              r.a_we  = 1'b1;
              r.a_val = s_reg.byte_mode ?
                        {hi(s_reg.a), lo(s_reg.a) | lo(opnd)} :
                        (s_reg.a | opnd);
            end
            op_excl_or: begin
              r.a_we  = 1'b1;
              r.a_val = s_reg.byte_mode ?
                        {hi(s_reg.a), lo(s_reg.a) ^ lo(opnd)} :
                        (s_reg.a ^ opnd);
            end
            op_load_acc: begin
              r.a_we  = 1'b1;
              r.a_val = opnd;
            end
            op_load_idx: begin
              r.x_we  = 1'b1;
              r.x_val = opnd;
            end
            op_store_acc,
            op_store_idx: begin
              wr_go   = 1'b1;
              wr_data = lane_merged;
            end
            op_exchange: begin
              r.a_we  = 1'b1;
              r.a_val = opnd;
              wr_go   = 1'b1;
              wr_data = s_reg.byte_mode ? lane_merged : s_reg.a;
            end
            op_compare: begin
              r.skip = cmp_skip;
            end
            op_increment_and_skip: begin
              wr_go   = 1'b1;
              wr_data = sum;
              r.skip  = (sum == WORD_ZERO && !s_reg.intr) ?
                        SKIP_ONE : SKIP_NONE;
              r.echo  = (sum == WORD_ZERO) && s_reg.intr;
              r.overflow_flag_set = (mem_rdata == WORD_MAX_POS);
            end
            default: begin
            end
          endcase
        end
      end
      st_write: begin
        if (mem_ack) begin
          r   = s_reg.pend;
          fin = 1'b1;
        end
      end
      default: begin
        fin = 1'b1;
      end
    endcase
    if (rd_go) begin
      s_next.mem = '{1'b1, 1'b0, rd_addr, WORD_ZERO};
    end
    if (wr_go) begin
      fin          = 1'b0;
      s_next.pend  = r;
      s_next.mem   = '{1'b1, 1'b1, wr_addr, wr_data};
      s_next.phase = st_write;
    end
    if (fin) begin
      s_next.phase    = st_idle;
      s_next.busy     = 1'b0;
      s_next.mem      = '0;
      s_next.res      = r;
      s_next.res.done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mem  = s_reg.mem;
  assign res  = s_reg.res;
  assign busy = s_reg.busy;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // a new start in the done cycle may raise busy again
  a_done_single_pulse: assert property (
    res.done |=> !res.done && (!busy || $past(start)))
    else $error("done not a single pulse");
  a_conj_byte_clear: assert property (
    res.done && s_reg.op == op_conj && s_reg.byte_mode
    |-> res.a_we && hi(res.a_val) == BYTE_ZERO)
    else $error("byte conjunction left high byte");
  a_or_byte_keep: assert property (
    res.done && s_reg.byte_mode &&
    (s_reg.op == op_incl_or || s_reg.op == op_excl_or)
    |-> hi(res.a_val) == hi(s_reg.a))
    else $error("byte or changed high byte");
  a_load_byte_zero: assert property (
    res.done && s_reg.byte_mode && (res.a_we || res.x_we) &&
    (s_reg.op == op_load_acc || s_reg.op == op_load_idx)
    |-> hi(res.a_we ? res.a_val : res.x_val) == BYTE_ZERO)
    else $error("byte load high byte not zero");
  a_store_word_data: assert property (
    mem.req && mem.we && !s_reg.byte_mode &&
    (s_reg.op == op_store_acc || s_reg.op == op_exchange)
    |-> mem.wdata == s_reg.a)
    else $error("word store data wrong");
  // first write cycle: the word read at the previous edge is the old word
  a_byte_store_merge: assert property (
    mem.req && $rose(mem.we) && s_reg.byte_mode &&
    s_reg.op == op_store_acc
    |-> (s_reg.ea[BYTE_SEL_BIT] == SEL_HIGH) ?
        (mem.wdata == {lo(s_reg.a), lo($past(mem_rdata))}) :
        (mem.wdata == {hi($past(mem_rdata)), lo(s_reg.a)}))
    else $error("byte store merge wrong");
  a_compare_equal_two: assert property (
    res.done && s_reg.op == op_compare
    |-> (res.skip == SKIP_TWO) == (s_reg.a == s_reg.opnd))
    else $error("compare skip two mismatch");
  a_echo_no_skip: assert property (
    res.done && res.echo
    |-> s_reg.intr && res.skip == SKIP_NONE && !res.overflow_flag_set)
    else $error("echo with skip or overflow");
  a_jump_target: assert property (
    res.done && s_reg.op == op_unconditional_jump
    |-> res.p_we && res.p_val == s_reg.ea && $past(start, 1))
    else $error("jump target wrong");
  a_jst_target: assert property (
    res.done && s_reg.op == op_jump_and_store_return
    |-> res.p_we && res.p_val == s_reg.ea + WORD_ONE)
    else $error("jump-and-store target wrong");
  a_scan_exhaust: assert property (
    res.done && s_reg.op == op_scan && res.x_we &&
    res.skip == SKIP_ONE |-> res.x_val == WORD_ZERO)
    else $error("scan skip with count left");
  a_scan_suspend: assert property (
    res.done && res.suspend
    |-> $past(irq_pending) && res.x_val != WORD_ZERO &&
        res.skip == SKIP_NONE)
    else $error("bad scan suspend");

  c_scan_match: cover property (
    res.done && s_reg.op == op_scan && res.x_we &&
    !res.suspend && res.skip == SKIP_NONE);
  c_scan_exhaust: cover property (
    res.done && s_reg.op == op_scan && res.skip == SKIP_ONE);
  c_scan_suspend: cover property (res.done && res.suspend);
  c_ims_echo: cover property (res.done && res.echo);

endmodule

`default_nettype wire

// File: verification/mre_mem_model.sv
// behavioural main memory facing the execute unit
// assumes requests are held until ack; delay sets extra wait cycles
`default_nettype none

module mre_mem_model
  import mre_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire mre_mem_req_t mem,
  input  wire logic [3:0]   delay,
  output logic              mem_ack,
  output mre_word_t         mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // storage and answer
  mre_word_t  mem_arr [256];
  logic [3:0] wait_cnt;

  // read data is only valid with ack; otherwise it toggles every cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 4'h0;
      mem_rdata <= 16'hA5A5;
    end else if (mem.req && !mem_ack && wait_cnt >= delay) begin
      mem_ack   <= 1'b1;
      wait_cnt  <= 4'h0;
      mem_rdata <= mem_arr[mem.addr[7:0]];
      if (mem.we) begin
        mem_arr[mem.addr[7:0]] <= mem.wdata;
      end
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem.req && !mem_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the memory-reference execute unit
// assumes mre_pkg, mre_execute_unit and mre_mem_model are compiled
`default_nettype none

module tb_top import mre_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam mre_word_t RET = 16'h0041;
  localparam mre_word_t INL = 16'h0077;

  logic         sys_clk         = 1'b0;
  logic         rst             = 1'b1;
  logic         start           = 1'b0;
  mre_cmd_t     cmd             = '0;
  logic         irq_pending     = 1'b0;
  logic         variant_hold_en = 1'b0;
  logic [3:0]   delay           = 4'h0;
  logic         mem_ack;
  mre_word_t    mem_rdata;
  mre_mem_req_t mem;
  mre_result_t  res;
  mre_result_t  r;
  logic         busy;
  int           num_errors      = 0;
  int           num_checks      = 0;

  always #50 sys_clk = ~sys_clk;

  mre_execute_unit u_dut (.sys_clk(sys_clk), .rst(rst), .start(start),
    .cmd(cmd), .irq_pending(irq_pending),
    .variant_hold_en(variant_hold_en), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem(mem), .res(res), .busy(busy));

  mre_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .mem(mem),
    .delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ==========================================================
  // helpers
  task automatic chk(input string n, input mre_word_t got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic put(input int a, input mre_word_t v);
    u_mem.mem_arr[a] = v;
  endtask

  function automatic mre_word_t get(input int a);
    return u_mem.mem_arr[a];
  endfunction

  // one command, result kept in r from the done cycle
  task automatic run(input mre_op_t op, input logic bm, ii,
                     input mre_word_t ea, a, x);
    int n;
    n = 0;
    @(posedge sys_clk);
    start <= 1'b1;
    cmd   <= '{op, bm, ii, ea, a, x, RET, INL};
    @(posedge sys_clk);
    start <= 1'b0;
    #1 r = res;
    if (op != op_unconditional_jump) begin
      chk("busy", busy, 1'b1);
    end
    while (n < 300 && r.done !== 1'b1) begin
      @(posedge sys_clk);
      #1 r = res;
      n++;
    end
    chk("done", r.done, 1'b1);
    chk("idle", busy, 1'b0);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_logic();
    put(16, 16'hF0CC);
    run(op_conj, 0, 0, 16'h0010, 16'h3C5A, 0);
    chk("and", r.a_val, 16'h3048);
    chk("a_we", r.a_we, 1'b1);
    run(op_incl_or, 0, 0, 16'h0010, 16'h3C5A, 0);
    chk("or", r.a_val, 16'hFCDE);
    run(op_excl_or, 0, 0, 16'h0010, 16'h3C5A, 0);
    chk("xor", r.a_val, 16'hCC96);
    put(17, 16'hA53C);
    run(op_conj, 1, 0, 16'h0022, 16'h7E0F, 0);
    chk("conjunction_byte_to_accumulator", r.a_val, 16'h0005);
    run(op_incl_or, 1, 0, 16'h0023, 16'h7E0F, 0);
    chk("orb", r.a_val, 16'h7E3F);
    run(op_excl_or, 1, 0, 16'h0022, 16'h7E0F, 0);
    chk("exclusive_or_byte_to_accumulator", r.a_val, 16'h7EAA);
  endtask

  task automatic t_load();
    put(18, 16'h8123);
    run(op_load_acc, 0, 0, 16'h0012, 16'hFFFF, 0);
    chk("lda", r.a_val, 16'h8123);
    run(op_load_idx, 0, 0, 16'h0012, 0, 16'hFFFF);
    chk("ldx", r.x_val, 16'h8123);
    chk("x_we", r.x_we, 1'b1);
    run(op_load_acc, 1, 0, 16'h0024, 16'hFFFF, 0);
    chk("load_accumulator_byte", r.a_val, 16'h0081);
    run(op_load_idx, 1, 0, 16'h0025, 0, 16'hFFFF);
    chk("load_index_byte", r.x_val, 16'h0023);
  endtask

  task automatic t_store();
    delay <= 4'h2;
    run(op_store_acc, 0, 0, 16'h0013, 16'hBEEF, 0);
    chk("sta", get(19), 16'hBEEF);
    run(op_store_idx, 0, 0, 16'h0014, 0, 16'h1234);
    chk("stx", get(20), 16'h1234);
    put(21, 16'hAA55);
    run(op_store_acc, 1, 0, 16'h002A, 16'h1277, 0);
    chk("store_accumulator_byte", get(21), 16'h7755);
    run(op_store_idx, 1, 0, 16'h002B, 0, 16'h3499);
    chk("store_index_byte", get(21), 16'h7799);
    delay <= 4'h0;
  endtask

  task automatic t_exch();
    put(22, 16'h5555);
    run(op_exchange, 0, 0, 16'h0016, 16'h1111, 0);
    chk("ema_a", r.a_val, 16'h5555);
    chk("ema_m", get(22), 16'h1111);
    put(23, 16'hC3D4);
    run(op_exchange, 1, 0, 16'h002F, 16'hFF66, 0);
    chk("exchange_memory_byte_a", r.a_val, 16'h00D4);
    chk("exchange_memory_byte_m", get(23), 16'hC366);
  endtask

  task automatic t_cmp();
    put(24, 16'h0100);
    put(25, 16'h0580);
    run(op_compare, 0, 0, 16'h0018, 16'h0200, 0);
    chk("gt", r.skip, SKIP_ONE);
    run(op_compare, 0, 0, 16'h0018, 16'h0100, 0);
    chk("eq", r.skip, SKIP_TWO);
    run(op_compare, 0, 0, 16'h0018, 16'h8000, 0);
    chk("lt", r.skip, SKIP_NONE);
    run(op_compare, 1, 0, 16'h0032, 16'h0105, 0);
    chk("gtb", r.skip, SKIP_ONE);
    run(op_compare, 1, 0, 16'h0032, 16'h0005, 0);
    chk("eqb", r.skip, SKIP_TWO);
    run(op_compare, 1, 0, 16'h0033, 16'h0080, 0);
    chk("zext", r.skip, SKIP_TWO);
  endtask

  task automatic t_inc();
    put(26, 16'hFFFF);
    put(27, 16'h7FFF);
    put(28, 16'hFFFF);
    run(op_increment_and_skip, 1, 0, 16'h001A, 0, 0);
    chk("inc0", get(26), 16'h0000);
    chk("skz", r.skip, SKIP_ONE);
    run(op_increment_and_skip, 0, 0, 16'h001B, 0, 0);
    chk("ov", r.overflow_flag_set, 1'b1);
    chk("noskp", r.skip, SKIP_NONE);
    run(op_increment_and_skip, 0, 1, 16'h001C, 0, 0);
    chk("echo", r.echo, 1'b1);
    chk("iskp", r.skip, SKIP_NONE);
    chk("iov", r.overflow_flag_set, 1'b0);
  endtask

  task automatic t_jump();
    run(op_unconditional_jump, 0, 0, 16'h0123, 0, 0);
    chk("jmp", r.p_val, 16'h0123);
    chk("p_we", r.p_we, 1'b1);
    run(op_jump_and_store_return, 1, 0, 16'h001E, 0, 0);
    chk("jst_m", get(30), RET);
    chk("jst_p", r.p_val, 16'h001F);
    chk("nodis", r.int_disable, 1'b0);
    chk("nohold", r.int_hold, 1'b0);
    variant_hold_en <= 1'b1;
    run(op_jump_and_store_return, 0, 1, 16'h001F, 0, 0);
    chk("ijst_m", get(31), INL);
    chk("dis", r.int_disable, 1'b1);
    chk("hold", r.int_hold, 1'b1);
    variant_hold_en <= 1'b0;
  endtask

  task automatic t_scan();
    put(2, 16'h0040);
    put(8'h41, 16'h0001);
    put(8'h42, 16'h0002);
    put(8'h43, 16'h0007);
    put(8'h44, 16'h0004);
    run(op_scan, 0, 0, 16'h0002, 16'h0007, 16'h0004);
    chk("match", r.skip, SKIP_NONE);
    chk("left", r.x_val, 16'h0002);
    run(op_scan, 0, 0, 16'h0002, 16'h0007, 16'h0002);
    chk("miss", r.skip, SKIP_ONE);
    chk("x0", r.x_val, 16'h0000);
    run(op_scan, 0, 0, 16'h0002, 16'h0007, 16'h0000);
    chk("empty", r.skip, SKIP_ONE);
    irq_pending <= 1'b1;
    delay <= 4'h3;
    run(op_scan, 0, 0, 16'h0002, 16'h0009, 16'h0004);
    chk("susp", r.suspend, 1'b1);
    chk("xsusp", r.x_val, 16'h0003);
    irq_pending <= 1'b0;
    run(op_scan, 0, 0, 16'h0002, 16'h0001, r.x_val);
    chk("resume", r.skip, SKIP_NONE);
    chk("xres", r.x_val, 16'h0000);
    delay <= 4'h0;
  endtask

  task automatic t_bscan();
    put(3, 16'h00A1);
    put(8'h51, 16'h0A0B);
    put(8'h52, 16'h0C0D);
    // byte mode is set in cmd in the same cycle as the start of the byte scan
    run(op_scan, 1, 0, 16'h0003, 16'h000B, 16'h0004);
    chk("bmatch", r.skip, SKIP_NONE);
    chk("bleft", r.x_val, 16'h0001);
    run(op_scan, 1, 0, 16'h0003, 16'h010B, 16'h0004);
    chk("b16", r.skip, SKIP_ONE);
  endtask

  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_logic();
    t_load();
    t_store();
    t_exch();
    t_cmp();
    t_inc();
    t_jump();
    t_scan();
    t_bscan();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
